// >>> hdl/wbtr_regs.vh
// constants for the wake bit-timing recovery register bank
`ifndef WBTR_REGS_VH
`define WBTR_REGS_VH

// register addresses, one 8-bit word per address
`define WBTR_ADDR_CAL_HIGH   7'h3A
`define WBTR_ADDR_CAL_LOW    7'h3B
`define WBTR_ADDR_CTRL_ONE   7'h3C
`define WBTR_ADDR_CTRL_TWO   7'h3D
`define WBTR_ADDR_UPPER      7'h3E
`define WBTR_ADDR_LOWER      7'h3F
`define WBTR_ADDR_STATUS     7'h4F

// reset values
`define WBTR_RST_CAL         8'h00
`define WBTR_RST_CTRL_ONE    8'h04
`define WBTR_RST_CTRL_TWO    8'h00
`define WBTR_RST_UPPER       8'hA8
`define WBTR_RST_LOWER       8'h98
`define WBTR_RST_STATUS      8'h00

// writable bit masks, all other positions read-only or reserved
`define WBTR_MASK_CTRL_ONE   8'h0D
`define WBTR_MASK_CTRL_TWO   8'h03
`define WBTR_MASK_STATUS_RC  8'h03

// field positions
`define WBTR_EN_BIT          0
`define WBTR_FILT_MSB        3
`define WBTR_FILT_LSB        2
`define WBTR_CLK_MSB         1
`define WBTR_CLK_LSB         0
`define WBTR_ST_UPPER_BIT    0
`define WBTR_ST_LOWER_BIT    1
`define WBTR_ST_ACTIVE_BIT   2

// frame layout: bits 0..6 address, bit 7 mode, bits 8..15 data
`define WBTR_FRAME_BITS      5'h10
`define WBTR_COUNT_MAX       5'h1F
`define WBTR_ADDR_MSB        6
`define WBTR_MODE_BIT        7
`define WBTR_DATA_LSB        8
`define WBTR_DATA_MSB        15
`define WBTR_ZERO_BYTE       8'h00

// filter select codes and time constants
`define WBTR_FILT_8          2'h0
`define WBTR_FILT_16         2'h1
`define WBTR_FILT_32         2'h2
`define WBTR_FILT_ADAPT      2'h3
`define WBTR_TC_8            6'h08
`define WBTR_TC_16           6'h10
`define WBTR_TC_32           6'h20

// falling edge spacing bands in bits, for adaptive mode
`define WBTR_GAP_A_LO        4'h2
`define WBTR_GAP_A_HI        4'h3
`define WBTR_GAP_B_LO        4'h4
`define WBTR_GAP_B_HI        4'h8
`define WBTR_GAP_C_LO        4'h9
`define WBTR_GAP_C_HI        4'hA

`endif

// >>> hdl/wbtr_shaper.v
// time-constant selection and bit-time clamping for the recovery unit
`timescale 1ns/1ps
`default_nettype none
`include "wbtr_regs.vh"

module wbtr_shaper #(
    parameter BT_W = 8
) (
    input  wire            clk,
    input  wire            rst_n,
    input  wire            ce,
    input  wire            enable,
    input  wire [1:0]      filterSelect,
    input  wire [BT_W-1:0] upperBound,
    input  wire [BT_W-1:0] lowerBound,
    input  wire [BT_W-1:0] bitTimeIn,
    input  wire            bitTimeValid,
    input  wire [3:0]      edgeGap,
    input  wire            edgeGapValid,
    output reg  [5:0]      timeConstant,
    output reg  [BT_W-1:0] clampedBitTime,
    output reg             clampedValid,
    output reg             upperHit,
    output reg             lowerHit
);

    reg [5:0] adaptTc;
    reg [5:0] next_adaptTc;
    reg [5:0] next_timeConstant;

    // gaps outside every band keep the last adaptive choice
    always @* begin
        next_adaptTc = adaptTc;
        if (edgeGapValid) begin
            if (edgeGap >= `WBTR_GAP_A_LO && edgeGap <= `WBTR_GAP_A_HI) begin
                next_adaptTc = `WBTR_TC_32;
            end else if (edgeGap >= `WBTR_GAP_B_LO &&
                         edgeGap <= `WBTR_GAP_B_HI) begin
                next_adaptTc = `WBTR_TC_16;
            end else if (edgeGap >= `WBTR_GAP_C_LO &&
                         edgeGap <= `WBTR_GAP_C_HI) begin
                next_adaptTc = `WBTR_TC_8;
            end
        end
        case (filterSelect)
            `WBTR_FILT_8:  next_timeConstant = `WBTR_TC_8;
            `WBTR_FILT_16: next_timeConstant = `WBTR_TC_16;
            `WBTR_FILT_32: next_timeConstant = `WBTR_TC_32;
            default:       next_timeConstant = next_adaptTc;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            adaptTc        <= `WBTR_TC_16;
            timeConstant   <= `WBTR_TC_16;
            clampedBitTime <= {BT_W{1'b0}};
            clampedValid   <= 1'b0;
            upperHit       <= 1'b0;
            lowerHit       <= 1'b0;
        end else if (ce) begin
            adaptTc      <= next_adaptTc;
            timeConstant <= next_timeConstant;
            clampedValid <= enable && bitTimeValid;
            upperHit     <= 1'b0;
            lowerHit     <= 1'b0;
            if (enable && bitTimeValid) begin
                if (bitTimeIn > upperBound) begin
                    clampedBitTime <= upperBound;
                    upperHit       <= 1'b1;
                end else if (bitTimeIn < lowerBound) begin
                    clampedBitTime <= lowerBound;
                    lowerHit       <= 1'b1;
                end else begin
                    clampedBitTime <= bitTimeIn;
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> hdl/wbtr_bank.v
// register bank and serial slave of the wake bit-timing recovery unit
`timescale 1ns/1ps
`default_nettype none
`include "wbtr_regs.vh"

// Contract
// - calibration high and low bytes are read-only, zero after reset.
// - filter select codes 0..3 give constant 8, 16, 32 or adaptive.
// - adaptive: gap 2-3 bits gives 32, 4-8 gives 16, 9-10 gives 8.
// - control one resets to 0x04; bit 0 enables recovery.
// - clock select codes 0..3 give 80, 40, 20, 10 MHz.
// - bit times above the upper limit are clamped; limit resets 0xA8.
// - bit times below the lower limit are clamped; limit resets 0x98.
// - frame is 16 bits: 7-bit address, mode bit, then data byte.
// - data bits D0..D7 travel in frame bits 8..15.
// - mode bit zero reads a status register without changing it.
// - mode bit one clears the clearable bits of a status register.
// - status bits are read-only or read-clear; only the latter clear.
// - status content stays until the host clears it.
// - reserved bit positions always read zero.
// - each address selects one whole register word.
module wbtr_bank #(
    parameter DATA_W = 8,
    parameter ADDR_W = 7
) (
    input  wire              clk,
    input  wire              rst_n,
    input  wire              ce,
    input  wire              spiSclk,
    input  wire              spiCsN,
    input  wire              spiMosi,
    output wire              spiMiso,
    output reg               spiMisoOe,
    input  wire [DATA_W-1:0] calibHigh,
    input  wire [DATA_W-1:0] calibLow,
    input  wire              calibValid,
    input  wire [DATA_W-1:0] bitTimeIn,
    input  wire              bitTimeValid,
    input  wire [3:0]        edgeGap,
    input  wire              edgeGapValid,
    output reg               recoveryEnable,
    output reg  [1:0]        recoveryClockSelect,
    output wire [5:0]        filterTimeConstant,
    output wire [DATA_W-1:0] clampedBitTime,
    output wire              clampedValid
);

    // pin synchronisers; stage one feeds stage two only
    reg sclkMeta;
    reg sclkSync;
    reg sclkLast;
    reg csnMeta;
    reg csnSync;
    reg csnLast;
    reg mosiMeta;
    reg mosiSync;

    wire sclkRise;
    wire sclkFall;
    wire frameStart;
    wire frameEnd;
    wire frameActive;

    // shift registers and frame bookkeeping
    reg [2*DATA_W-1:0] rxShift;
    reg [2*DATA_W-1:0] txShift;
    reg [4:0]          bitCount;
    reg                seenRise;
    reg [DATA_W-1:0]   replyData;

    // register storage
    reg [DATA_W-1:0] calibValueHigh;
    reg [DATA_W-1:0] calibValueLow;
    reg [DATA_W-1:0] recoveryControlOne;
    reg [DATA_W-1:0] recoveryControlTwo;
    reg [DATA_W-1:0] bitTimeUpperBound;
    reg [DATA_W-1:0] bitTimeLowerBound;
    reg [DATA_W-1:0] recoveryStatus;

    // decoded frame
    wire [ADDR_W-1:0] frameAddr;
    wire              frameMode;
    wire [DATA_W-1:0] frameData;
    wire              frameGood;
    wire              frameCommit;

    reg  [DATA_W-1:0] readValue;
    reg  [DATA_W-1:0] next_recoveryControlOne;
    reg  [DATA_W-1:0] next_recoveryControlTwo;
    reg  [DATA_W-1:0] next_bitTimeUpperBound;
    reg  [DATA_W-1:0] next_bitTimeLowerBound;
    reg  [DATA_W-1:0] next_recoveryStatus;
    reg  [DATA_W-1:0] statusClear;
    reg  [DATA_W-1:0] statusSet;

    wire upperHit;
    wire lowerHit;

    assign sclkRise    = sclkSync && !sclkLast;
    assign sclkFall    = !sclkSync && sclkLast;
    assign frameStart  = csnLast && !csnSync;
    assign frameEnd    = !csnLast && csnSync;
    assign frameActive = !csnSync;

    // first frame bit on the wire lands in bit 0 of rxShift
    assign frameAddr   = rxShift[`WBTR_ADDR_MSB:0];
    assign frameMode   = rxShift[`WBTR_MODE_BIT];
    assign frameData   = rxShift[`WBTR_DATA_MSB:`WBTR_DATA_LSB];
    // frames of any other length are dropped whole
    assign frameGood   = (bitCount == `WBTR_FRAME_BITS);
    assign frameCommit = frameEnd && frameGood;

    assign spiMiso = txShift[0];

    always @(posedge clk) begin
        if (!rst_n) begin
            sclkMeta <= 1'b0;
            sclkSync <= 1'b0;
            sclkLast <= 1'b0;
            csnMeta  <= 1'b1;
            csnSync  <= 1'b1;
            csnLast  <= 1'b1;
            mosiMeta <= 1'b0;
            mosiSync <= 1'b0;
        end else if (ce) begin
            sclkMeta <= spiSclk;
            sclkSync <= sclkMeta;
            sclkLast <= sclkSync;
            csnMeta  <= spiCsN;
            csnSync  <= csnMeta;
            csnLast  <= csnSync;
            mosiMeta <= spiMosi;
            mosiSync <= mosiMeta;
        end
    end

    // whole-word decode; unmapped addresses read as zero
    always @* begin
        readValue = `WBTR_ZERO_BYTE;
        if (frameAddr == `WBTR_ADDR_CAL_HIGH) begin
            readValue = calibValueHigh;
        end else if (frameAddr == `WBTR_ADDR_CAL_LOW) begin
            readValue = calibValueLow;
        end else if (frameAddr == `WBTR_ADDR_CTRL_ONE) begin
            readValue = recoveryControlOne & `WBTR_MASK_CTRL_ONE;
        end else if (frameAddr == `WBTR_ADDR_CTRL_TWO) begin
            readValue = recoveryControlTwo & `WBTR_MASK_CTRL_TWO;
        end else if (frameAddr == `WBTR_ADDR_UPPER) begin
            readValue = bitTimeUpperBound;
        end else if (frameAddr == `WBTR_ADDR_LOWER) begin
            readValue = bitTimeLowerBound;
        end else if (frameAddr == `WBTR_ADDR_STATUS) begin
            readValue = recoveryStatus & `WBTR_MASK_STATUS_RC;
            readValue[`WBTR_ST_ACTIVE_BIT] = recoveryEnable;
        end
    end

    // writes touch only writable positions of control registers
    always @* begin
        next_recoveryControlOne = recoveryControlOne;
        next_recoveryControlTwo = recoveryControlTwo;
        next_bitTimeUpperBound  = bitTimeUpperBound;
        next_bitTimeLowerBound  = bitTimeLowerBound;
        statusClear             = `WBTR_ZERO_BYTE;
        if (frameCommit && frameMode) begin
            if (frameAddr == `WBTR_ADDR_CTRL_ONE) begin
                next_recoveryControlOne = frameData
                                        & `WBTR_MASK_CTRL_ONE;
            end else if (frameAddr == `WBTR_ADDR_CTRL_TWO) begin
                next_recoveryControlTwo = frameData
                                        & `WBTR_MASK_CTRL_TWO;
            end else if (frameAddr == `WBTR_ADDR_UPPER) begin
                next_bitTimeUpperBound = frameData;
            end else if (frameAddr == `WBTR_ADDR_LOWER) begin
                next_bitTimeLowerBound = frameData;
            end else if (frameAddr == `WBTR_ADDR_STATUS) begin
                statusClear = `WBTR_MASK_STATUS_RC;
            end
        end
    end

    // a clamp event in the clearing cycle survives the clear
    always @* begin
        statusSet = `WBTR_ZERO_BYTE;
        statusSet[`WBTR_ST_UPPER_BIT] = upperHit;
        statusSet[`WBTR_ST_LOWER_BIT] = lowerHit;
        next_recoveryStatus = ((recoveryStatus & ~statusClear)
                              | statusSet) & `WBTR_MASK_STATUS_RC;
    end

    // serial shifting: sample on rising clock, launch on falling clock
    always @(posedge clk) begin
        if (!rst_n) begin
            rxShift   <= {2*DATA_W{1'b0}};
            txShift   <= {2*DATA_W{1'b0}};
            bitCount  <= 5'h00;
            seenRise  <= 1'b0;
            spiMisoOe <= 1'b0;
        end else if (ce) begin
            spiMisoOe <= frameActive;
            if (frameStart) begin
                bitCount <= 5'h00;
                seenRise <= 1'b0;
                // answer: zero byte, then the word captured last frame
                txShift  <= {replyData, `WBTR_ZERO_BYTE};
            end else if (frameActive) begin
                if (sclkRise) begin
                    rxShift  <= {mosiSync, rxShift[2*DATA_W-1:1]};
                    seenRise <= 1'b1;
                    if (bitCount != `WBTR_COUNT_MAX) begin
                        bitCount <= bitCount + 5'h01;
                    end
                end
                if (sclkFall && seenRise) begin
                    txShift <= {1'b0, txShift[2*DATA_W-1:1]};
                end
            end
        end
    end

    // register state
    always @(posedge clk) begin
        if (!rst_n) begin
            calibValueHigh     <= `WBTR_RST_CAL;
            calibValueLow      <= `WBTR_RST_CAL;
            recoveryControlOne <= `WBTR_RST_CTRL_ONE;
            recoveryControlTwo <= `WBTR_RST_CTRL_TWO;
            bitTimeUpperBound  <= `WBTR_RST_UPPER;
            bitTimeLowerBound  <= `WBTR_RST_LOWER;
            recoveryStatus     <= `WBTR_RST_STATUS;
            replyData          <= `WBTR_ZERO_BYTE;
            recoveryEnable     <= 1'b0;
            recoveryClockSelect <= 2'h0;
        end else if (ce) begin
            // calibration bytes follow the oscillator logic, never the host
            if (calibValid) begin
                calibValueHigh <= calibHigh;
                calibValueLow  <= calibLow;
            end
            recoveryControlOne <= next_recoveryControlOne;
            recoveryControlTwo <= next_recoveryControlTwo;
            bitTimeUpperBound  <= next_bitTimeUpperBound;
            bitTimeLowerBound  <= next_bitTimeLowerBound;
            recoveryStatus     <= next_recoveryStatus;
            // value before this frame's write or clear is what is returned
            if (frameCommit) begin
                replyData <= readValue;
            end
            recoveryEnable <= next_recoveryControlOne[`WBTR_EN_BIT];
            recoveryClockSelect <=
                next_recoveryControlTwo[`WBTR_CLK_MSB:`WBTR_CLK_LSB];
        end
    end

    wbtr_shaper #(
        .BT_W (DATA_W)
    ) shaper (
        .clk            (clk),
        .rst_n          (rst_n),
        .ce             (ce),
        .enable         (recoveryEnable),
        .filterSelect   (recoveryControlOne[`WBTR_FILT_MSB:`WBTR_FILT_LSB]),
        .upperBound     (bitTimeUpperBound),
        .lowerBound     (bitTimeLowerBound),
        .bitTimeIn      (bitTimeIn),
        .bitTimeValid   (bitTimeValid),
        .edgeGap        (edgeGap),
        .edgeGapValid   (edgeGapValid),
        .timeConstant   (filterTimeConstant),
        .clampedBitTime (clampedBitTime),
        .clampedValid   (clampedValid),
        .upperHit       (upperHit),
        .lowerHit       (lowerHit)
    );

endmodule

`default_nettype wire

// >>> testbench/wbtr_bank_checker.sv
// concurrent checks on the ports of the recovery register bank
`timescale 1ns/1ps
`default_nettype none
module wbtr_bank_checker #(
    parameter DATA_W = 8,
    parameter ADDR_W = 7
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              ce,
    input wire logic              spiSclk,
    input wire logic              spiCsN,
    input wire logic              spiMosi,
    input wire logic              spiMiso,
    input wire logic              spiMisoOe,
    input wire logic [DATA_W-1:0] calibHigh,
    input wire logic [DATA_W-1:0] calibLow,
    input wire logic              calibValid,
    input wire logic [DATA_W-1:0] bitTimeIn,
    input wire logic              bitTimeValid,
    input wire logic [3:0]        edgeGap,
    input wire logic              edgeGapValid,
    input wire logic              recoveryEnable,
    input wire logic [1:0]        recoveryClockSelect,
    input wire logic [5:0]        filterTimeConstant,
    input wire logic [DATA_W-1:0] clampedBitTime,
    input wire logic              clampedValid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // long enough for commit and output update to have landed
    sequence csIdle;
        spiCsN [*8];
    endsequence
    sequence csActive;
        !spiCsN [*5];
    endsequence
    a_reset_values: assert property ($rose(rst_n) |-> !recoveryEnable
        && recoveryClockSelect == 2'h0 && filterTimeConstant == 6'h10)
        else $error("control outputs not at reset values");
    a_tc_legal: assert property (filterTimeConstant inside
        {6'h08, 6'h10, 6'h20}) else $error("time constant not 8, 16 or 32");
    // a committed filter select shows in the time constant four edges after the chip select rise is first sampled
    a_tc_cause: assert property ($changed(filterTimeConstant) |->
        $past(edgeGapValid) || $past(edgeGapValid, 2) ||
        ($past(spiCsN, 4) && !$past(spiCsN, 5)))
        else $error("time constant moved without cause");
    a_valid_cause: assert property (clampedValid |->
        $past(bitTimeValid) && $past(recoveryEnable))
        else $error("clamped sample without enabled input sample");
    a_value_holds: assert property (!clampedValid |->
        $stable(clampedBitTime)) else $error("clamped value moved");
    a_oe_active: assert property (csActive |-> spiMisoOe)
        else $error("data out not driven in frame");
    a_oe_idle: assert property (spiCsN [*5] |-> !spiMisoOe)
        else $error("data out driven outside frame");
    a_idle_stable: assert property (csIdle |-> $stable(recoveryEnable)
        && $stable(recoveryClockSelect)) else $error("control moved idle");
    a_frame_cause: assert property ($changed(recoveryEnable)
        || $changed(recoveryClockSelect) |-> $past(spiCsN, 3)
        && !$past(spiCsN, 4)) else $error("control moved inside a frame");
endmodule
bind wbtr_bank wbtr_bank_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W))
    wbtr_bank_checker_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
    .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .calibHigh(calibHigh),
    .calibLow(calibLow), .calibValid(calibValid), .bitTimeIn(bitTimeIn),
    .bitTimeValid(bitTimeValid), .edgeGap(edgeGap),
    .edgeGapValid(edgeGapValid), .recoveryEnable(recoveryEnable),
    .recoveryClockSelect(recoveryClockSelect),
    .filterTimeConstant(filterTimeConstant),
    .clampedBitTime(clampedBitTime), .clampedValid(clampedValid));
`default_nettype wire

// >>> testbench/wbtr_spi_host.sv
// serial host model that sends 16-bit frames to the register bank
`timescale 1ns/1ps
`default_nettype none
module wbtr_spi_host (
    input  wire logic clk,
    output var  logic spiSclk,
    output var  logic spiCsN,
    output var  logic spiMosi,
    input  wire logic spiMiso
);
    int halfCycles = 4;
    initial begin
        spiSclk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b1;
    end
    task automatic xfer(input logic [6:0] addr, input logic mode,
                        input logic [7:0] data, output logic [15:0] reply);
        logic [15:0] frame;
        frame = {data, mode, addr};
        @(negedge clk);
        spiCsN = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 16; i++) begin
            spiMosi = frame[i];
            repeat (halfCycles) @(negedge clk);
            spiSclk = 1'b1;
            reply[i] = spiMiso;
            repeat (halfCycles) @(negedge clk);
            spiSclk = 1'b0;
        end
        repeat (halfCycles) @(negedge clk);
        spiCsN = 1'b1;
        // a released line must not keep showing the last bit
        spiMosi = ~spiMosi;
        repeat (8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the recovery register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk;
    logic        rst_n;
    logic        ce;
    wire         spiSclk;
    wire         spiCsN;
    wire         spiMosi;
    wire         spiMiso;
    wire         spiMisoOe;
    logic [7:0]  calibHigh;
    logic [7:0]  calibLow;
    logic        calibValid;
    logic [7:0]  bitTimeIn;
    logic        bitTimeValid;
    logic [3:0]  edgeGap;
    logic        edgeGapValid;
    wire         recoveryEnable;
    wire  [1:0]  recoveryClockSelect;
    wire  [5:0]  filterTimeConstant;
    wire  [7:0]  clampedBitTime;
    wire         clampedValid;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [15:0] reply;
    logic [7:0]  rstVals [0:5] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'hA8, 8'h98};
    // rows: mode and address byte, data, value read back afterwards
    // the first two rows write the oscillator trim words, which must stay zero
    logic [23:0] rows [0:9] = '{
        24'hBAFF00, 24'hBBFF00, 24'hBCFF0D, 24'hBDFF03, 24'hBE5454,
        24'hBF4C4C, 24'hBD0101, 24'hBC0505, 24'hC0FF00, 24'h3CFF05};

    wbtr_bank wbtr_bank_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
        .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .calibHigh(calibHigh),
        .calibLow(calibLow), .calibValid(calibValid), .bitTimeIn(bitTimeIn),
        .bitTimeValid(bitTimeValid), .edgeGap(edgeGap),
        .edgeGapValid(edgeGapValid), .recoveryEnable(recoveryEnable),
        .recoveryClockSelect(recoveryClockSelect),
        .filterTimeConstant(filterTimeConstant),
        .clampedBitTime(clampedBitTime), .clampedValid(clampedValid));
    wbtr_spi_host wbtr_spi_host_inst (.clk(clk), .spiSclk(spiSclk),
        .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso));

    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, want, seen);
        end
    endtask
    // the reply of a frame carries the register of the frame before it
    task automatic rd(input logic [6:0] addr, input logic [7:0] want);
        wbtr_spi_host_inst.xfer(addr, 1'b0, 8'h00, reply);
        wbtr_spi_host_inst.xfer(addr, 1'b0, 8'h00, reply);
        chk("leading byte", reply[7:0], 8'h00);
        chk("read data", reply[15:8], want);
    endtask
    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        wbtr_spi_host_inst.xfer(addr, 1'b1, data, reply);
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("enable", {7'h0, recoveryEnable}, 8'h00);
        chk("clock select", {6'h0, recoveryClockSelect}, 8'h00);
        chk("time constant", {2'h0, filterTimeConstant}, 8'h10);
    endtask
    task automatic gap(input logic [3:0] g, input logic [7:0] want);
        edgeGap = g;
        edgeGapValid = 1'b1;
        @(negedge clk);
        edgeGapValid = 1'b0;
        repeat (2) @(negedge clk);
        chk("adaptive constant", {2'h0, filterTimeConstant}, want);
    endtask
    task automatic clamp(input logic [7:0] t, input logic [7:0] want);
        bitTimeIn = t;
        bitTimeValid = 1'b1;
        @(negedge clk);
        bitTimeValid = 1'b0;
        for (int k = 0; k < 4 && clampedValid !== 1'b1; k++) @(negedge clk);
        chk("clamp valid", {7'h0, clampedValid}, 8'h01);
        chk("clamped", clampedBitTime, want);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        calibHigh = 8'h00;
        calibLow = 8'h00;
        calibValid = 1'b0;
        bitTimeIn = 8'h00;
        bitTimeValid = 1'b0;
        edgeGap = 4'h0;
        edgeGapValid = 1'b0;
        do_reset();
        wbtr_spi_host_inst.xfer(7'h3A, 1'b0, 8'h00, reply);
        for (int i = 1; i < 7; i++) begin
            wbtr_spi_host_inst.xfer(7'h3A + 7'(i), 1'b0, 8'h00, reply);
            chk("reset value", reply[15:8], rstVals[i-1]);
        end
        foreach (rows[r]) begin
            wbtr_spi_host_inst.xfer(rows[r][22:16], rows[r][23],
                                    rows[r][15:8], reply);
            rd(rows[r][22:16], rows[r][7:0]);
        end
        for (int c = 0; c < 4; c++) begin
            wr(7'h3D, 8'(c));
            chk("clock select", {6'h0, recoveryClockSelect}, 8'(c));
        end
        for (int f = 0; f < 3; f++) begin
            wr(7'h3C, 8'((f << 2) | 1));
            chk("time constant", {2'h0, filterTimeConstant}, 8'(8 << f));
        end
        // halved limits suit 40 MHz at 500k, never the overflowing pairs
        wr(7'h3D, 8'h01);
        wbtr_spi_host_inst.halfCycles = 9;
        wr(7'h3C, 8'h0D);
        wbtr_spi_host_inst.halfCycles = 4;
        gap(4'h9, 8'h08);
        gap(4'h3, 8'h20);
        gap(4'h4, 8'h10);
        gap(4'hA, 8'h08);
        gap(4'hC, 8'h08);
        gap(4'h2, 8'h20);
        gap(4'h8, 8'h10);
        // with the clock enable low a gap event must not move the constant
        ce = 1'b0;
        gap(4'h3, 8'h10);
        ce = 1'b1;
        clamp(8'h60, 8'h54);
        clamp(8'h40, 8'h4C);
        clamp(8'h54, 8'h54);
        clamp(8'h4C, 8'h4C);
        clamp(8'h50, 8'h50);
        rd(7'h4F, 8'h07);
        rd(7'h4F, 8'h07);
        wr(7'h4F, 8'hFF);
        rd(7'h4F, 8'h04);
        calibHigh = 8'h5A;
        calibLow = 8'hC3;
        calibValid = 1'b1;
        @(negedge clk);
        calibValid = 1'b0;
        rd(7'h3A, 8'h5A);
        rd(7'h3B, 8'hC3);
        do_reset();
        rd(7'h3E, 8'hA8);
        rd(7'h3C, 8'h04);
        complete_run();
    end
endmodule
`default_nettype wire
